// ===== design/rxu_receiver.sv
`timescale 1ns/1ps
`default_nettype none
module rxu_receiver #(
  parameter int DEPTH = rxu_pkg::FIFO_DEPTH,
  parameter int DIVW  = rxu_pkg::DIV_W
) (
  input  wire logic            core_clk_in,
  input  wire logic            reset_in,
  input  wire logic            uart_enable_bit_in,
  input  wire logic            receiver_enable_bit_in,
  input  wire logic            word_length_select_in,
  input  wire logic            parity_check_enable_in,
  input  wire logic            parity_type_select_in,
  input  wire logic            rx_interrupt_enable_in,
  input  wire logic [DIVW-1:0] baud_divider_in,
  input  wire logic            rx_pin_in,
  input  wire logic            status_read_in,
  input  wire logic            data_read_in,
  output logic [7:0]           serial_data_buffer_out,
  output logic                 rx_ninth_bit_out,
  output logic                 rx_data_available_flag_out,
  output logic                 overrun_flag_out,
  output logic                 noise_flag_out,
  output logic                 framing_error_flag_out,
  output logic                 parity_error_flag_out,
  output logic                 receiver_idle_flag_out,
  output logic                 receiver_enable_out,
  output logic                 rx_irq_out
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] ONE_C   = CNT_W'(1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("rxu_receiver: DEPTH must be a power of two, 2 or more");
  end
  if (DIVW < 1) begin : g_divw_chk
    $error("rxu_receiver: DIVW must be at least 1");
  end
  // entry packing and phase compare below assume this package layout
  if (rxu_pkg::ENTRY_W != rxu_pkg::WORD_W + 2 || rxu_pkg::POS_NINTH != 8
      || rxu_pkg::POS_PARITY_ERROR_FLAG != 9 || rxu_pkg::POS_FRAMING_ERROR_FLAG != 10) begin : g_entry_chk
    $error("rxu_receiver: entry layout must be word plus two flags");
  end
  if (rxu_pkg::PHASE_W != 4
      || int'(rxu_pkg::VOTE_PHASE) >= rxu_pkg::OVERSAMPLE) begin : g_phase_chk
    $error("rxu_receiver: vote phase must fit the 4-bit phase counter");
  end
  if (int'(rxu_pkg::BITS_LONG) > rxu_pkg::WORD_W
      || rxu_pkg::BITS_SHORT >= rxu_pkg::BITS_LONG) begin : g_bits_chk
    $error("rxu_receiver: word lengths must fit the shifter");
  end

  // -------- state --------
  rxu_pkg::rxu_state_e             state_q;
  logic [rxu_pkg::PHASE_W-1:0]     phase_q;
  logic [3:0]                      bits_q;
  logic [rxu_pkg::WORD_W-1:0]      shreg_q;
  logic                            noise_q;
  logic                            idle_q;
  logic                            armed_q;
  logic                            ovr_q;
  logic                            nf_q;
  logic                            irq_q;
  logic [rxu_pkg::ENTRY_W-1:0]     mem_q [DEPTH];
  logic [PTR_W-1:0]                wr_ptr_q;
  logic [PTR_W-1:0]                rd_ptr_q;
  logic [CNT_W-1:0]                cnt_q;
  logic [rxu_pkg::ENTRY_W-1:0]     head_q;

  // -------- combinational --------
  logic                            rx_active;
  logic                            tick;
  logic                            vote;
  logic                            noisy;
  logic                            sample_now;
  logic [3:0]                      word_bits;
  logic                            start_ok;
  logic                            frame_done;
  logic                            clr_seq;
  logic                            pop;
  logic                            push;
  logic                            overrun_set;
  logic [rxu_pkg::WORD_W-1:0]      word;
  logic                            parity_error_flag_bit;
  logic                            frame_noise;
  logic [rxu_pkg::ENTRY_W-1:0]     head;
  logic [rxu_pkg::ENTRY_W-1:0]     entry_new;
  logic [PTR_W-1:0]                rd_ptr_d;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = p + 1'b1;
  endfunction : ptr_inc

  assign rx_active = uart_enable_bit_in & receiver_enable_bit_in;

  rxu_oversampler #(
    .DIVW (DIVW)
  ) u_sampler (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .enable_in   (rx_active),
    .divider_in  (baud_divider_in),
    .pin_in      (rx_pin_in),
    .tick_out    (tick),
    .vote_out    (vote),
    .noisy_out   (noisy)
  );

  // votes taken on samples at phases 7, 8 and 9
  assign sample_now = tick && (phase_q == rxu_pkg::VOTE_PHASE);
  assign word_bits  = word_length_select_in ? rxu_pkg::BITS_LONG
                                            : rxu_pkg::BITS_SHORT;
  assign start_ok   = (state_q == rxu_pkg::RXU_START) && sample_now && !vote;
  // only one stop bit ever sampled, whatever the transmitter sends
  assign frame_done = rx_active && (state_q == rxu_pkg::RXU_STOP)
                   && sample_now;

  // 8-bit words sit one place high in the shifter
  assign word = word_length_select_in ? shreg_q
                                      : {1'b0, shreg_q[8:1]};
  assign parity_error_flag_bit = parity_check_enable_in
                  && ((^word) != parity_type_select_in);
  assign frame_noise = noise_q | noisy;
  // framing bit from the stop vote, parity result, then the word
  assign entry_new   = {!vote, parity_error_flag_bit, word};

  assign clr_seq     = data_read_in && armed_q;
  assign pop         = clr_seq && (cnt_q != '0);
  // a pop in the same cycle frees a slot for the arriving word
  assign push        = frame_done && ((cnt_q != DEPTH_C) || pop);
  assign overrun_set = frame_done && !push;

  // -------- bit timing --------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      phase_q <= '0;
    else if (!rx_active || state_q == rxu_pkg::RXU_IDLE)
      phase_q <= '0;
    else if (tick)
      phase_q <= phase_q + 1'b1;
  end

  // -------- frame sequencer --------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= rxu_pkg::RXU_IDLE;
    end else if (!rx_active) begin
      state_q <= rxu_pkg::RXU_IDLE;
    end else begin
      unique case (state_q)
        rxu_pkg::RXU_IDLE: begin
          if (tick && !vote)
            state_q <= rxu_pkg::RXU_START;
        end
        rxu_pkg::RXU_START: begin
          if (sample_now) begin
            state_q <= vote ? rxu_pkg::RXU_IDLE
                            : rxu_pkg::RXU_DATA;
          end
        end
        rxu_pkg::RXU_DATA: begin
          if (sample_now) begin
            if (bits_q + 1'b1 == word_bits)
              state_q <= rxu_pkg::RXU_STOP;
          end
        end
        rxu_pkg::RXU_STOP: begin
          if (sample_now)
            state_q <= vote ? rxu_pkg::RXU_IDLE
                            : rxu_pkg::RXU_HOLD;
        end
        rxu_pkg::RXU_HOLD: begin
          // a held-low break line must not look like a new start
          if (tick && vote && !noisy)
            state_q <= rxu_pkg::RXU_IDLE;
        end
        default: state_q <= rxu_pkg::RXU_IDLE;
      endcase
    end
  end

  // data bit counter, restarted by every start vote
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      bits_q <= '0;
    else if (!rx_active)
      bits_q <= '0;
    else if (sample_now && state_q == rxu_pkg::RXU_START)
      bits_q <= '0;
    else if (sample_now && state_q == rxu_pkg::RXU_DATA)
      bits_q <= bits_q + 1'b1;
  end

  // -------- shifter, never visible to software --------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      shreg_q <= '0;
    else if (rx_active && state_q == rxu_pkg::RXU_DATA && sample_now)
      shreg_q <= {vote, shreg_q[8:1]};
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      noise_q <= 1'b0;
    else if (!rx_active || (start_ok && !noisy))
      noise_q <= 1'b0;
    else if (start_ok)
      noise_q <= 1'b1;
    else if (sample_now && noisy && state_q == rxu_pkg::RXU_DATA)
      noise_q <= 1'b1;
  end

  // -------- idle status --------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      idle_q <= rxu_pkg::IDLE_RESET;
    else if (!rx_active)
      idle_q <= 1'b1;
    else if (frame_done)
      idle_q <= 1'b1;
    else if (start_ok)
      idle_q <= 1'b0;
  end

  // -------- receive FIFO --------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end else if (push) begin
      mem_q[wr_ptr_q] <= entry_new;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      wr_ptr_q <= '0;
    else if (!uart_enable_bit_in)
      wr_ptr_q <= '0;
    else if (push)
      wr_ptr_q <= ptr_inc(wr_ptr_q);
  end

  // read pointer moves on a pop and falls back to zero on disable
  always_comb begin
    rd_ptr_d = rd_ptr_q;
    if (!uart_enable_bit_in)
      rd_ptr_d = '0;
    else if (pop)
      rd_ptr_d = ptr_inc(rd_ptr_q);
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      rd_ptr_q <= '0;
    else
      rd_ptr_q <= rd_ptr_d;
  end

  // occupancy; a push and a pop in one cycle leave it alone
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      cnt_q <= '0;
    else if (!uart_enable_bit_in)
      cnt_q <= '0;
    else if (push && !pop)
      cnt_q <= cnt_q + ONE_C;
    else if (pop && !push)
      cnt_q <= cnt_q - ONE_C;
  end

  // head kept in flops so the buffer outputs are registered, not a mux;
  // it looks ahead to the slot that the read pointer holds next
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      head_q <= '0;
    else if (push && wr_ptr_q == rd_ptr_d)
      head_q <= entry_new;
    else
      head_q <= mem_q[rd_ptr_d];
  end

  // -------- read sequence: status access arms, data read clears --------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      armed_q <= 1'b0;
    else if (!uart_enable_bit_in || data_read_in)
      armed_q <= 1'b0;
    else if (status_read_in)
      armed_q <= 1'b1;
  end

  // -------- error flags, set wins over the read-pair clear --------
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      ovr_q <= 1'b0;
    else if (!uart_enable_bit_in)
      ovr_q <= 1'b0;
    else if (overrun_set)
      ovr_q <= 1'b1;
    else if (clr_seq)
      ovr_q <= 1'b0;
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      nf_q <= 1'b0;
    else if (!uart_enable_bit_in)
      nf_q <= 1'b0;
    else if (push && frame_noise)
      nf_q <= 1'b1;
    else if (clr_seq)
      nf_q <= 1'b0;
  end

  // noise alone never requests; it rides the transfer request
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in)
      irq_q <= 1'b0;
    else
      irq_q <= rx_interrupt_enable_in && (push || overrun_set);
  end

  // -------- outputs --------
  // stale after a flush, but the framing and parity flags are masked by the empty count
  assign head = head_q;

  assign serial_data_buffer_out     = head[7:0];
  assign rx_ninth_bit_out           = head[rxu_pkg::POS_NINTH];
  assign rx_data_available_flag_out = (cnt_q != '0);
  assign framing_error_flag_out     = (cnt_q != '0)
                                    && head[rxu_pkg::POS_FRAMING_ERROR_FLAG];
  assign parity_error_flag_out      = (cnt_q != '0)
                                    && head[rxu_pkg::POS_PARITY_ERROR_FLAG];
  assign overrun_flag_out           = ovr_q;
  assign noise_flag_out             = nf_q;
  assign receiver_idle_flag_out     = idle_q;
  assign receiver_enable_out        = rx_active;
  assign rx_irq_out                 = irq_q;

endmodule : rxu_receiver
`default_nettype wire

// ===== design/rxu_pkg.sv
// Summary of operation
// - accept 8-bit words, or 9-bit with ninth-bit field
// - recovery at 16x baud, shifter per bit
// - each bit decided by three-sample majority vote
// - after stop bit, move word into buffer
// - shift serial data in least significant bit first
// - buffer is a two-word FIFO
// - full FIFO: set overrun, keep contents, interrupt
// - enabled receiver searches the pin for start
// - data-available while FIFO holds data; interrupt on move
// - data-available clears after status then data read
// - overrun and noise clear by same read pair
// - break ends as framing error with zero word
// - after bad stop wait for high line
// - idle flag low from start to stop
// - noise flag rises with data-available, no interrupt
// - framing error on low first stop bit
// - framing and parity flags travel with word
// - parity checked only when enabled, odd or even
// - shift register hidden, data only via buffer
// - receiver always expects exactly one stop bit
// - disabling the UART flushes buffer, clears flags, sets idle
package rxu_pkg;

  localparam int          FIFO_DEPTH = 2;
  localparam int          OVERSAMPLE = 16;
  localparam int          PHASE_W    = $clog2(OVERSAMPLE);
  localparam int          DIV_W      = 8;
  localparam int          WORD_W     = 9;
  localparam int          ENTRY_W    = 11;
  localparam int          POS_NINTH  = 8;
  localparam int          POS_PARITY_ERROR_FLAG   = 9;
  localparam int          POS_FRAMING_ERROR_FLAG   = 10;
  localparam logic [3:0]  VOTE_PHASE = 4'h9;
  localparam logic [3:0]  BITS_SHORT = 4'h8;
  localparam logic [3:0]  BITS_LONG  = 4'h9;
  localparam logic        IDLE_RESET = 1'b1;

  typedef enum logic [4:0] {
    RXU_IDLE  = 5'b00001,
    RXU_START = 5'b00010,
    RXU_DATA  = 5'b00100,
    RXU_STOP  = 5'b01000,
    RXU_HOLD  = 5'b10000
  } rxu_state_e;

endpackage : rxu_pkg

// ===== design/rxu_oversampler.sv
`timescale 1ns/1ps
`default_nettype none
module rxu_oversampler #(
  parameter int DIVW = rxu_pkg::DIV_W
) (
  input  wire logic            core_clk_in,
  input  wire logic            reset_in,
  input  wire logic            enable_in,
  input  wire logic [DIVW-1:0] divider_in,
  input  wire logic            pin_in,
  output logic                 tick_out,
  output logic                 vote_out,
  output logic                 noisy_out
);

  logic            sync1_q;
  logic            sync2_q;
  logic [DIVW-1:0] cnt_q;
  logic            tick_q;
  logic            tick2_q;
  logic [2:0]      samp_q;

  if (DIVW < 1) begin : g_divw_chk
    $error("rxu_oversampler: DIVW must be at least 1");
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // divider+1 clocks per 16x tick
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (!enable_in) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == divider_in) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // tick is delayed so the vote already holds the newest sample
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      samp_q  <= 3'h7;
      tick2_q <= 1'b0;
    end else begin
      tick2_q <= tick_q;
      if (tick_q)
        samp_q <= {samp_q[1:0], sync2_q};
    end
  end

  assign tick_out  = tick2_q;
  assign vote_out  = (samp_q[0] & samp_q[1]) | (samp_q[1] & samp_q[2])
                   | (samp_q[0] & samp_q[2]);
  assign noisy_out = !((&samp_q) || !(|samp_q));

endmodule : rxu_oversampler
`default_nettype wire

// ===== tb/rxu_receiver_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rxu_receiver_chk (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic uart_enable_bit_in,
  input wire logic receiver_enable_bit_in,
  input wire logic rx_interrupt_enable_in,
  input wire logic status_read_in,
  input wire logic data_read_in,
  input wire logic rx_data_available_flag_out,
  input wire logic overrun_flag_out,
  input wire logic noise_flag_out,
  input wire logic framing_error_flag_out,
  input wire logic parity_error_flag_out,
  input wire logic receiver_idle_flag_out,
  input wire logic receiver_enable_out,
  input wire logic rx_irq_out
);
  logic arm_q;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      arm_q <= 1'b0;
    end else if (!uart_enable_bit_in || data_read_in) begin
      arm_q <= 1'b0;
    end else if (status_read_in) begin
      arm_q <= 1'b1;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  property p_en;
    receiver_enable_out == (uart_enable_bit_in && receiver_enable_bit_in);
  endproperty
  a_en: assert property (p_en) else $error("effective enable wrong");
  property p_start;
    $fell(receiver_idle_flag_out) |-> $past(receiver_enable_out);
  endproperty
  a_start: assert property (p_start) else $error("start while disabled");
  property p_empty;
    !rx_data_available_flag_out |-> !framing_error_flag_out && !parity_error_flag_out;
  endproperty
  a_empty: assert property (p_empty) else $error("error flag with empty buffer");
  property p_off;
    !uart_enable_bit_in |=> !rx_data_available_flag_out && !overrun_flag_out
      && !noise_flag_out && receiver_idle_flag_out;
  endproperty
  a_off: assert property (p_off) else $error("disable did not flush");
  property p_irq;
    $rose(rx_data_available_flag_out) && rx_interrupt_enable_in |-> ##[0:1] rx_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("no request on new word");
  property p_pulse;
    rx_irq_out |=> !rx_irq_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("request wider than a pulse");
  property p_mask;
    !rx_interrupt_enable_in && !$past(rx_interrupt_enable_in)
      && !$past(rx_interrupt_enable_in, 2) |-> !rx_irq_out;
  endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
  property p_noarm;
    data_read_in && !arm_q && overrun_flag_out && uart_enable_bit_in |=> overrun_flag_out;
  endproperty
  a_noarm: assert property (p_noarm) else $error("overrun cleared without status");
  property p_clr;
    data_read_in && arm_q && uart_enable_bit_in && receiver_idle_flag_out
      |=> !overrun_flag_out && !noise_flag_out;
  endproperty
  a_clr: assert property (p_clr) else $error("read pair left sticky flag");
  property p_noise;
    $rose(noise_flag_out) |-> ##[0:1] rx_data_available_flag_out;
  endproperty
  a_noise: assert property (p_noise) else $error("noise without data");
  property p_idle;
    $rose(rx_data_available_flag_out) |-> ##[0:1] receiver_idle_flag_out;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle after stop");
  c_ovr: cover property ($rose(overrun_flag_out));
  c_nf: cover property ($rose(noise_flag_out));
  c_fe: cover property (data_read_in && arm_q && framing_error_flag_out);
endmodule : rxu_receiver_chk
bind rxu_receiver rxu_receiver_chk u_chk (
  .core_clk_in                (core_clk_in),
  .reset_in                   (reset_in),
  .uart_enable_bit_in         (uart_enable_bit_in),
  .receiver_enable_bit_in     (receiver_enable_bit_in),
  .rx_interrupt_enable_in     (rx_interrupt_enable_in),
  .status_read_in             (status_read_in),
  .data_read_in               (data_read_in),
  .rx_data_available_flag_out (rx_data_available_flag_out),
  .overrun_flag_out           (overrun_flag_out),
  .noise_flag_out             (noise_flag_out),
  .framing_error_flag_out     (framing_error_flag_out),
  .parity_error_flag_out      (parity_error_flag_out),
  .receiver_idle_flag_out     (receiver_idle_flag_out),
  .receiver_enable_out        (receiver_enable_out),
  .rx_irq_out                 (rx_irq_out)
);
`default_nettype wire

// ===== tb/rxu_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module rxu_line_model (
  input  wire logic clk_in,
  output var logic  line_out
);
  initial line_out = 1'b1;
  task automatic put(input logic v, input int bc, input int g);
    for (int c = 0; c < bc; c++) begin
      @(posedge clk_in);
      line_out <= (c == g || c == g + 1) ? ~v : v; // glitch spans one 16x tick
    end
  endtask : put
  task automatic send(input logic [15:0] w, input int n, input logic stp, input int gb,
                      input int bc);
    put(1'b0, bc, -9);
    for (int i = 0; i < n; i++) begin
      put(w[i], bc, (i == gb) ? 18 : -9);
    end
    put(stp, bc, -9);
    if (!stp) begin
      put(1'b1, bc, -9);
    end
  endtask : send
endmodule : rxu_line_model
`default_nettype wire

// ===== tb/uart_receiver_with_error_flags_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module uart_receiver_with_error_flags_tb_top;
  localparam int BC = 32; // clocks per bit at divider 1
  logic core_clk_in, reset_in, uart_en, rx_en, wl, pen, pts, rx_interrupt_enable, st_rd, dt_rd;
  logic [7:0]  dat;
  logic        nin, avail, ovr, nf, fe, pe, idle, irq;
  wire logic   pin;
  logic [10:0] expq[$];
  logic        armed = 1'b0;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          seed;
  rxu_receiver u_dut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .uart_enable_bit_in(uart_en),
    .receiver_enable_bit_in(rx_en), .word_length_select_in(wl),
    .parity_check_enable_in(pen), .parity_type_select_in(pts),
    .rx_interrupt_enable_in(rx_interrupt_enable), .baud_divider_in(8'h01), .rx_pin_in(pin),
    .status_read_in(st_rd), .data_read_in(dt_rd), .serial_data_buffer_out(dat),
    .rx_ninth_bit_out(nin), .rx_data_available_flag_out(avail), .overrun_flag_out(ovr),
    .noise_flag_out(nf), .framing_error_flag_out(fe), .parity_error_flag_out(pe),
    .receiver_idle_flag_out(idle), .receiver_enable_out(), .rx_irq_out(irq));
  rxu_line_model u_line (.clk_in(core_clk_in), .line_out(pin));
  task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic rd(input logic s);
    st_rd <= s;
    @(posedge core_clk_in);
    st_rd <= 1'b0;
    dt_rd <= 1'b1;
    @(posedge core_clk_in);
    dt_rd <= 1'b0;
    @(posedge core_clk_in);
  endtask : rd
  task automatic frame(input logic [8:0] w, input logic stp, input int gb, input logic keep);
    logic [8:0] m;
    m = wl ? w : {1'b0, w[7:0]};
    if (keep) expq.push_back({~stp, pen & ((^m) != pts), m});
    u_line.send({7'h00, m}, wl ? 9 : 8, stp, gb, BC);
    repeat (4) @(posedge core_clk_in);
  endtask : frame
  always @(posedge core_clk_in) begin
    if (dt_rd && armed && expq.size() > 0)
      check("entry", {fe, pe, nin, dat}, expq.pop_front());
    if (st_rd) armed = 1'b1;
    else if (dt_rd) armed = 1'b0;
  end
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    repeat (40000) @(posedge core_clk_in);
    fail_count++;
    complete_run();
  end
  initial begin
    seed = 32'h12b2;
    {reset_in, uart_en, rx_en, wl, pen, pts, rx_interrupt_enable, st_rd, dt_rd} = 9'h1c0;
    repeat (20) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rx_interrupt_enable <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      {wl, pen, pts} <= k[2:0];
      @(posedge core_clk_in);
      repeat (2) frame(9'($random(seed)), 1'b1, -1, 1'b1);
      repeat (2) rd(1'b1);
    end
    {wl, pen, pts, rx_interrupt_enable} <= 4'h0;
    @(posedge core_clk_in);
    for (int i = 0; i < 3; i++) frame(9'($random(seed)), 1'b1, -1, i < 2);
    check("overrun", ovr, 1'b1);
    rd(1'b0);
    check("overrun", ovr, 1'b1);
    rd(1'b1);
    check("overrun", ovr, 1'b0);
    rd(1'b1);
    check("available", avail, 1'b0);
    rx_interrupt_enable <= 1'b1;
    frame(9'($random(seed)), 1'b1, 2, 1'b1);
    check("noise", nf, 1'b1);
    rd(1'b1);
    check("noise", nf, 1'b0);
    expq.push_back(11'h400);
    u_line.send(16'h0000, 13, 1'b0, -1, BC);
    repeat (4) @(posedge core_clk_in);
    check("idle", idle, 1'b1);
    rd(1'b1);
    frame(9'($random(seed)), 1'b0, -1, 1'b1);
    frame(9'($random(seed)), 1'b1, -1, 1'b1);
    repeat (2) rd(1'b1);
    frame(9'($random(seed)), 1'b1, -1, 1'b0);
    uart_en <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    check("available", avail, 1'b0);
    check("idle", idle, 1'b1);
    uart_en <= 1'b1;
    frame(9'($random(seed)), 1'b1, -1, 1'b1);
    rd(1'b1);
    check("pending", 11'(expq.size()), 11'h000);
    complete_run();
  end
endmodule : uart_receiver_with_error_flags_tb_top
`default_nettype wire
